/* core/afc_top.sv */
// front-end control: mux, excitation, bias, gain, reference, clock select, status
// Behaviour
// - any analog pin can be chosen as positive or negative input
// - excitation current sources can be routed to chosen input pins
// - selectable bias voltage can be applied to chosen input pins
// - monitor code shorts both inputs at mid-supply for offset measurement
// - monitor code connects the temperature sensor to the converter
// - monitor code presents a quarter of the analog supply difference
// - burn-out sources pull selected inputs toward a supply when enabled
// - three-bit gain field selects gain 1 to 128 in powers of two
// - gains 64 and 128 use analog gain 32 plus digital scaling
// - two-bit control enables the amplifier or bypasses it
// - rail detection acts only while its mode register enable is set
// - four flags show amplifier outputs within 150 mV of either rail
// - reference monitor sets one low flag per external reference pair while the mode register conversion bit is set
// - internal reference stays powered down after reset until enabled
// - two-bit field enables positive and negative reference buffers independently
// - internal oscillator after reset; external clock when register selects it
// - modulator clock is selected converter clock divided by sixteen
`timescale 1ns/1ns
`default_nettype none
module afc_top #(
    parameter int unsigned MOD_DIV = afc_pkg::MOD_DIV
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [7:0]            i_paddr,
    input  wire logic [31:0]           i_pwdata,
    input  wire logic [3:0]            i_pstrb,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    input  wire afc_pkg::afc_sense_t   i_sense,
    input  wire logic                  i_int_osc_tick,
    input  wire logic                  i_ext_clk_tick,
    output afc_pkg::afc_steer_t        o_steer,
    output logic                       o_ext_clk_sel,
    output logic                       o_mod_tick
);
    // configuration registers
    logic [31:0] mux_reg;
    logic [31:0] exc_reg;
    logic [31:0] bias_reg;
    logic [31:0] gain_reg;
    logic [31:0] conv_mode_reg;
    logic [31:0] ref_reg;
    logic [31:0] clk_reg;

    // sense synchronisers
    afc_pkg::afc_sense_t sense_s1;
    afc_pkg::afc_sense_t sense_s2;
    logic [1:0]          osc_s;
    logic [1:0]          ext_s;
    logic                osc_d;
    logic                ext_d;

    // APB decode
    wire access   = i_psel && i_penable;
    wire wr_cycle = access && i_pwrite;
    wire hit_mux  = (i_paddr == afc_pkg::OFS_MUX);
    wire hit_exc  = (i_paddr == afc_pkg::OFS_EXC);
    wire hit_bias = (i_paddr == afc_pkg::OFS_BIAS);
    wire hit_gain = (i_paddr == afc_pkg::OFS_GAIN);
    wire hit_mode = (i_paddr == afc_pkg::OFS_MODE);
    wire hit_ref  = (i_paddr == afc_pkg::OFS_REF);
    wire hit_clk  = (i_paddr == afc_pkg::OFS_CLK);
    wire hit_stat = (i_paddr == afc_pkg::OFS_STATUS);
    wire mapped   = hit_mux | hit_exc | hit_bias | hit_gain | hit_mode | hit_ref
                  | hit_clk | hit_stat;

    wire [31:0] wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // live status: rail flags gated by the detect enable, reference flags by the conversion mode bit
    wire rail_detect_enable = conv_mode_reg[afc_pkg::MODE_RAIL_EN];
    wire pos_out_near_high_flag = rail_detect_enable & sense_s2.pos_high;
    wire pos_out_near_low_flag  = rail_detect_enable & sense_s2.pos_low;
    wire neg_out_near_high_flag = rail_detect_enable & sense_s2.neg_high;
    wire neg_out_near_low_flag  = rail_detect_enable & sense_s2.neg_low;
    wire conv_active            = conv_mode_reg[afc_pkg::MODE_CONV];
    wire refmon_low_flag_a      = conv_active & sense_s2.ref_low_a;
    wire refmon_low_flag_b      = conv_active & sense_s2.ref_low_b;

    wire [31:0] status_word = {26'h0, refmon_low_flag_b, refmon_low_flag_a,
                               neg_out_near_low_flag, neg_out_near_high_flag,
                               pos_out_near_low_flag, pos_out_near_high_flag};

    wire [31:0] rd_mux = ({32{hit_mux}}  & mux_reg)
                       | ({32{hit_exc}}  & exc_reg)
                       | ({32{hit_bias}} & bias_reg)
                       | ({32{hit_gain}} & gain_reg)
                       | ({32{hit_mode}} & conv_mode_reg)
                       | ({32{hit_ref}}  & ref_reg)
                       | ({32{hit_clk}}  & clk_reg)
                       | ({32{hit_stat}} & status_word);

    // zero wait states
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end

    // register writes; reset leaves internal reference off and internal oscillator selected
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mux_reg       <= afc_pkg::RST_MUX;
            exc_reg       <= afc_pkg::RST_EXC;
            bias_reg      <= afc_pkg::RST_BIAS;
            gain_reg      <= afc_pkg::RST_GAIN;
            conv_mode_reg <= afc_pkg::RST_MODE;
            ref_reg       <= afc_pkg::RST_REF;
            clk_reg       <= afc_pkg::RST_CLK;
        end else if (wr_cycle) begin
            if (hit_mux)  mux_reg       <= merge(mux_reg, i_pwdata, wmask);
            if (hit_exc)  exc_reg       <= merge(exc_reg, i_pwdata, wmask);
            if (hit_bias) bias_reg      <= merge(bias_reg, i_pwdata, wmask);
            if (hit_gain) gain_reg      <= merge(gain_reg, i_pwdata, wmask);
            if (hit_mode) conv_mode_reg <= merge(conv_mode_reg, i_pwdata, wmask);
            if (hit_ref)  ref_reg       <= merge(ref_reg, i_pwdata, wmask);
            if (hit_clk)  clk_reg       <= merge(clk_reg, i_pwdata, wmask);
        end
    end

    // two-stage synchronisers on analog comparator and clock pin inputs
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sense_s1 <= '0;
            sense_s2 <= '0;
            osc_s    <= 2'h0;
            ext_s    <= 2'h0;
            osc_d    <= 1'b0;
            ext_d    <= 1'b0;
        end else begin
            sense_s1 <= i_sense;
            sense_s2 <= sense_s1;
            osc_s    <= {osc_s[0], i_int_osc_tick};
            ext_s    <= {ext_s[0], i_ext_clk_tick};
            osc_d    <= osc_s[1];
            ext_d    <= ext_s[1];
        end
    end

    // converter clock selection and edge detect
    wire ext_sel   = clk_reg[afc_pkg::CLK_EXT];
    wire osc_rise  = osc_s[1] & ~osc_d;
    wire ext_rise  = ext_s[1] & ~ext_d;
    wire conv_tick = ext_sel ? ext_rise : osc_rise;
    assign o_ext_clk_sel = ext_sel;

    afc_mod_clk #(
        .DIV (MOD_DIV)
    ) u_mod_clk (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_clk_en   (conv_tick),
        .o_mod_tick (o_mod_tick)
    );

    // pin routing decode: one-hot route per excitation source and bias mask
    wire [3:0]  exc_a_pin = exc_reg[afc_pkg::EXC_A_LSB +: 4];
    wire [3:0]  exc_b_pin = exc_reg[afc_pkg::EXC_B_LSB +: 4];
    wire [15:0] exc_a_oh  = exc_reg[afc_pkg::EXC_A_EN] ? (16'h0001 << exc_a_pin) : 16'h0000;
    wire [15:0] exc_b_oh  = exc_reg[afc_pkg::EXC_B_EN] ? (16'h0001 << exc_b_pin) : 16'h0000;

    // gain: above 32 the amplifier holds 32 and the rest is a digital shift
    wire [2:0] gain_code = gain_reg[afc_pkg::GAIN_LSB +: 3];
    wire [1:0] amp_ctl   = gain_reg[afc_pkg::AMPC_LSB +: 2];
    wire       gain_hi   = (gain_code == afc_pkg::GAIN_64) || (gain_code == afc_pkg::GAIN_128);
    wire [2:0] amp_gain  = gain_hi ? afc_pkg::GAIN_32 : gain_code;
    wire [1:0] dig_shift = gain_hi ? 2'(gain_code - afc_pkg::GAIN_32) : 2'h0;

    wire [4:0] pos_sel = mux_reg[afc_pkg::MUX_POS_LSB +: 5];
    wire [4:0] neg_sel = mux_reg[afc_pkg::MUX_NEG_LSB +: 5];

    // registered steering outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_steer <= '0;
        end else begin
            o_steer.pos_sel     <= pos_sel;
            o_steer.neg_sel     <= neg_sel;
            o_steer.exc_a_route <= exc_a_oh;
            o_steer.exc_b_route <= exc_b_oh;
            o_steer.bias_route  <= bias_reg[afc_pkg::NUM_AIN-1:0];
            o_steer.burnout_en  <= mux_reg[afc_pkg::MUX_BO_BIT];
            o_steer.burnout_dir <= mux_reg[afc_pkg::MUX_BO_DIR];
            o_steer.amp_gain    <= amp_gain;
            o_steer.dig_shift   <= dig_shift;
            o_steer.amp_bypass  <= (amp_ctl != afc_pkg::AMP_ON);
            o_steer.ref_int_on  <= ref_reg[afc_pkg::REF_INT_EN];
            o_steer.ref_buf_en  <= ref_reg[afc_pkg::REF_BUF_LSB +: 2];
        end
    end
endmodule
`default_nettype wire

/* core/afc_pkg.sv */
// package: register map, field layouts, reset values and shared types for the front-end control
package afc_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_MUX      = 8'h00;
    localparam logic [7:0] OFS_EXC      = 8'h04;
    localparam logic [7:0] OFS_BIAS     = 8'h08;
    localparam logic [7:0] OFS_GAIN     = 8'h0C;
    localparam logic [7:0] OFS_MODE     = 8'h10;
    localparam logic [7:0] OFS_REF      = 8'h14;
    localparam logic [7:0] OFS_CLK      = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1C;

    localparam int unsigned NUM_AIN = 16;
    localparam int unsigned SEL_W   = 5;

    // input selector codes: 0..15 pins, then monitor sources
    localparam logic [4:0] SEL_MID   = 5'h10;
    localparam logic [4:0] SEL_TEMP  = 5'h11;
    localparam logic [4:0] SEL_SUPPLY = 5'h12;

    // mux register fields
    localparam int unsigned MUX_POS_LSB = 0;
    localparam int unsigned MUX_NEG_LSB = 8;
    localparam int unsigned MUX_BO_BIT  = 16;
    localparam int unsigned MUX_BO_DIR  = 17;

    // excitation register fields
    localparam int unsigned EXC_A_LSB  = 0;
    localparam int unsigned EXC_B_LSB  = 8;
    localparam int unsigned EXC_A_EN   = 5;
    localparam int unsigned EXC_B_EN   = 13;

    // gain register fields
    localparam int unsigned GAIN_LSB   = 0;
    localparam int unsigned AMPC_LSB   = 4;

    localparam logic [2:0] GAIN_32  = 3'h5;
    localparam logic [2:0] GAIN_64  = 3'h6;
    localparam logic [2:0] GAIN_128 = 3'h7;

    // amplifier control codes
    localparam logic [1:0] AMP_ON = 2'h0;

    // mode register fields
    localparam int unsigned MODE_RAIL_EN = 0;
    localparam int unsigned MODE_CONV    = 1;

    // reference register fields
    localparam int unsigned REF_INT_EN  = 0;
    localparam int unsigned REF_BUF_LSB = 4;

    // clock register fields
    localparam int unsigned CLK_EXT = 0;

    localparam int unsigned MOD_DIV = 16;

    localparam logic [31:0] RST_MUX  = 32'h0000_0100;
    localparam logic [31:0] RST_EXC  = 32'h0000_0000;
    localparam logic [31:0] RST_BIAS = 32'h0000_0000;
    localparam logic [31:0] RST_GAIN = 32'h0000_0000;
    localparam logic [31:0] RST_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_REF  = 32'h0000_0000;
    localparam logic [31:0] RST_CLK  = 32'h0000_0000;

    // analog comparator inputs from the front end
    typedef struct packed {
        logic pos_high;
        logic pos_low;
        logic neg_high;
        logic neg_low;
        logic ref_low_a;
        logic ref_low_b;
    } afc_sense_t;

    // analog steering outputs
    typedef struct packed {
        logic [4:0]  pos_sel;
        logic [4:0]  neg_sel;
        logic [15:0] exc_a_route;
        logic [15:0] exc_b_route;
        logic [15:0] bias_route;
        logic        burnout_en;
        logic        burnout_dir;
        logic [2:0]  amp_gain;
        logic [1:0]  dig_shift;
        logic        amp_bypass;
        logic        ref_int_on;
        logic [1:0]  ref_buf_en;
    } afc_steer_t;

endpackage

/* core/afc_mod_clk.sv */
// divider making the modulator clock enable from the selected converter clock
`timescale 1ns/1ns
`default_nettype none
module afc_mod_clk #(
    parameter int unsigned DIV = 16
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_clk_en,
    output logic      o_mod_tick
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;
    wire           wrap = i_clk_en && (count == LAST);

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            count <= '0;
            o_mod_tick <= 1'b0;
        end else begin
            o_mod_tick <= wrap;
            if (i_clk_en) begin
                count <= wrap ? '0 : count + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/afc_top_properties.sv */
// checker: port-level properties of the front-end control
`timescale 1ns/1ns
`default_nettype none
module afc_top_properties (
    input wire logic                i_ref_clk,
    input wire logic                i_sys_rst,
    input wire logic                i_psel,
    input wire logic                i_penable,
    input wire logic                i_pwrite,
    input wire logic [7:0]          i_paddr,
    input wire logic [31:0]         i_pwdata,
    input wire logic [3:0]          i_pstrb,
    input wire logic [31:0]         o_prdata,
    input wire logic                o_pready,
    input wire logic                o_pslverr,
    input wire afc_pkg::afc_steer_t o_steer,
    input wire logic                o_ext_clk_sel,
    input wire logic                o_mod_tick
);
    wire wr     = i_psel && i_penable && i_pwrite;
    wire wr_ref = wr && i_paddr == afc_pkg::OFS_REF;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_ready_high: assert property (o_pready)
        else $error("pready low");
    a_unmapped_err: assert property (i_psel && i_penable && i_paddr > 8'h1C |-> o_pslverr)
        else $error("no error on unmapped access");
    a_rdata_holds: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
        else $error("read data changed outside setup");
    a_clk_select: assert property (wr && i_paddr == afc_pkg::OFS_CLK && i_pstrb[0]
        |=> o_ext_clk_sel == $past(i_pwdata[0])) else $error("clock select wrong");
    a_bypass_ctl: assert property (wr && i_paddr == afc_pkg::OFS_GAIN && i_pstrb[0]
        |-> ##2 o_steer.amp_bypass == ($past(i_pwdata[5:4], 2) != afc_pkg::AMP_ON))
        else $error("bypass wrong");
    a_pos_select: assert property (wr && i_paddr == afc_pkg::OFS_MUX && i_pstrb[0]
        |-> ##2 o_steer.pos_sel == $past(i_pwdata[4:0], 2)) else $error("pos select wrong");
    a_bias_route: assert property (wr && i_paddr == afc_pkg::OFS_BIAS && i_pstrb[1:0] == 2'h3
        |-> ##2 o_steer.bias_route == $past(i_pwdata[15:0], 2)) else $error("bias wrong");
    a_digital_scale: assert property (o_steer.dig_shift != 2'h0
        |-> o_steer.amp_gain == afc_pkg::GAIN_32) else $error("analog gain above 32");
    a_ref_by_write: assert property ($rose(o_steer.ref_int_on) |-> $past(wr_ref, 2))
        else $error("reference on without write");
    a_tick_single: assert property (o_mod_tick |=> !o_mod_tick [*8])
        else $error("modulator ticks too close");
endmodule
bind afc_top afc_top_properties u_props (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_steer(o_steer),
    .o_ext_clk_sel(o_ext_clk_sel), .o_mod_tick(o_mod_tick));
`default_nettype wire

/* verif/afc_sensor_model.sv */
// sensor side: comparator levels and the two clock pins
`timescale 1ns/1ns
`default_nettype none
module afc_sensor_model (
    input  wire logic          i_ext_run,
    input  wire logic [5:0]    i_fault,
    output afc_pkg::afc_sense_t o_sense,
    output logic               o_int_osc,
    output logic               o_ext_clk
);
    // comparators follow the commanded fault pattern
    assign o_sense = afc_pkg::afc_sense_t'(i_fault);
    initial o_int_osc = 1'b0;
    always #285 o_int_osc = ~o_int_osc;
    // external clock stands low while not running
    initial o_ext_clk = 1'b0;
    always #335 o_ext_clk = i_ext_run ? ~o_ext_clk : 1'b0;
endmodule
`default_nettype wire

/* verif/adc_frontend_control_tb_top.sv */
// testbench: register access, steering, status flags and clock selection
`timescale 1ns/1ns
`default_nettype none
module adc_frontend_control_tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ext_run = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic [5:0]  fault = 6'h00;
    logic [4:0]  sel;
    logic        pready, pslverr, se, int_osc, ext_clk, ext_sel, tick;
    afc_pkg::afc_sense_t sense;
    afc_pkg::afc_steer_t steer;
    logic [31:0] rstv [7] = '{afc_pkg::RST_MUX, afc_pkg::RST_EXC, afc_pkg::RST_BIAS,
        afc_pkg::RST_GAIN, afc_pkg::RST_MODE, afc_pkg::RST_REF, afc_pkg::RST_CLK};
    int          err_count = 0, check_count = 0, ni = 0, ne = 0, nt = 0, nt0;
    always #50 clk = ~clk;
    always @(posedge int_osc) ni++;
    always @(posedge ext_clk) ne++;
    always @(posedge tick) nt++;
    afc_sensor_model PART (.i_ext_run(ext_run), .i_fault(fault), .o_sense(sense),
        .o_int_osc(int_osc), .o_ext_clk(ext_clk));
    afc_top #(.MOD_DIV(16)) DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sense(sense), .i_int_osc_tick(int_osc), .i_ext_clk_tick(ext_clk),
        .o_steer(steer), .o_ext_clk_sel(ext_sel), .o_mod_tick(tick));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    // pin edges of the selected clock between two modulator ticks
    task automatic span;
        int c0;
        @(posedge tick);
        c0 = ext_sel ? ne : ni;
        @(posedge tick);
        chk("mod_span", 32'((ext_sel ? ne : ni) - c0), 32'd16);
    endtask
    task automatic end_of_test;
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset_value", rd, rstv[i]);
        end
        chk("ref_after_reset", steer.ref_int_on, 1'b0);
        chk("clk_after_reset", ext_sel, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", se, 1'b1);
        for (int i = 0; i < 4; i++) begin
            sel = (i == 3) ? 5'd15 : afc_pkg::SEL_MID + 5'(i);
            apb(1'b1, afc_pkg::OFS_MUX, {14'h0, {2{i == 3}}, 3'h0, sel, 3'h0, 5'(i)});
            settle();
            chk("pos_sel", steer.pos_sel, 5'(i));
            chk("neg_sel", steer.neg_sel, sel);
            chk("burnout", {steer.burnout_en, steer.burnout_dir}, {2{i == 3}});
        end
        // only byte lane 0 enabled: the negative select byte must keep its value
        pstrb <= 4'h1;
        apb(1'b1, afc_pkg::OFS_MUX, 32'h0000_1F00);
        pstrb <= 4'hF;
        settle();
        chk("strobe_pos", steer.pos_sel, 5'h00);
        chk("strobe_neg", steer.neg_sel, 5'h0F);
        apb(1'b1, afc_pkg::OFS_REF, 32'h30);
        settle();
        chk("ref_both_buf", {steer.ref_int_on, steer.ref_buf_en}, 3'b011);
        apb(1'b1, afc_pkg::OFS_REF, 32'h10);
        settle();
        chk("ref_pos_buf", {steer.ref_int_on, steer.ref_buf_en}, 3'b001);
        // internal reference on with buffers off, before excitation is used
        apb(1'b1, afc_pkg::OFS_REF, 32'h01);
        settle();
        chk("ref_on", {steer.ref_int_on, steer.ref_buf_en}, 3'b100);
        apb(1'b1, afc_pkg::OFS_EXC, 32'h2C23);
        apb(1'b1, afc_pkg::OFS_BIAS, 32'hA5C3);
        settle();
        chk("exc_a", steer.exc_a_route, 32'h0008);
        chk("exc_b", steer.exc_b_route, 32'h1000);
        chk("bias", steer.bias_route, 32'hA5C3);
        for (int g = 0; g < 8; g++) begin
            // gain 1 with bypass for a single-ended input
            apb(1'b1, afc_pkg::OFS_GAIN, 32'(g) | (g == 0 ? 32'h10 : 32'h0));
            settle();
            chk("amp_gain", steer.amp_gain, g > 5 ? afc_pkg::GAIN_32 : 3'(g));
            chk("dig_shift", steer.dig_shift, g > 5 ? 2'(g - 5) : 2'h0);
            chk("bypass", steer.amp_bypass, g == 0);
        end
        fault <= 6'h3F;
        repeat (5) @(posedge clk);
        apb(1'b0, afc_pkg::OFS_STATUS, 32'h0);
        chk("flags_off", rd, 32'h0);
        apb(1'b1, afc_pkg::OFS_MODE, 32'h1);
        apb(1'b0, afc_pkg::OFS_STATUS, 32'h0);
        chk("rail_only", rd, 32'h0F);
        apb(1'b1, afc_pkg::OFS_MODE, 32'h3);
        for (int i = 0; i < 7; i++) begin
            fault <= (i < 6) ? 6'h20 >> i : 6'h00;
            repeat (5) @(posedge clk);
            apb(1'b0, afc_pkg::OFS_STATUS, 32'h0);
            chk("status", rd, (i < 6) ? 32'h1 << i : 32'h0);
        end
        span();
        apb(1'b1, afc_pkg::OFS_CLK, 32'h1);
        repeat (10) @(posedge clk);
        chk("ext_sel", ext_sel, 1'b1);
        nt0 = nt;
        repeat (200) @(posedge clk);
        chk("ticks_stopped", 32'(nt - nt0), 32'h0);
        ext_run <= 1'b1;
        span();
        // reset again in mid-run: reference off, internal clock, mux default
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("ref_rerun", steer.ref_int_on, 1'b0);
        chk("clk_rerun", ext_sel, 1'b0);
        chk("neg_rerun", steer.neg_sel, 32'(afc_pkg::RST_MUX[afc_pkg::MUX_NEG_LSB +: 5]));
        apb(1'b0, afc_pkg::OFS_REF, 32'h0);
        chk("ref_reg_rerun", rd, afc_pkg::RST_REF);
        end_of_test();
    end
endmodule
`default_nettype wire
